// >>> verif/pbodsw_pins.sv
`timescale 1ns/100ps
// Pads, far-side drivers and pull-ups outside the block
module pbodsw_pins
    import pbodsw_pkg::*;
(
    input wire logic [PORTB_W-1:0] portb_out,
    input wire logic [PORTB_W-1:0] portb_oe,
    input wire logic [PORTB_W-1:0] portb_ext,
    input wire logic [OD_W-1:0] od_out,
    input wire logic [OD_W-1:0] od_oe,
    input wire logic [OD_W-1:0] od_ext,
    input wire logic [2:0] tx_out,
    input wire logic [2:0] tx_oe,
    output logic [PORTB_W-1:0] portb_lvl,
    output logic [OD_W-1:0] od_lvl,
    output logic [2:0] tx_lvl
);
    // Driven pads win, released ones show the far side
    assign portb_lvl = (portb_oe & portb_out) | (~portb_oe & portb_ext);
    assign od_lvl = (od_oe & od_out) | (~od_oe & od_ext);
    // Released transmit pads go to the pull-up
    assign tx_lvl = (tx_oe & tx_out) | ~tx_oe;
endmodule // pbodsw_pins

// >>> verif/pbodsw_props.sv
`timescale 1ns/100ps
// Bus timing and pad relations seen at the top ports
module pbodsw_props
    import pbodsw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PORTB_W-1:0] port_b_out,
    input wire logic [PORTB_W-1:0] port_b_oe,
    input wire logic [OD_W-1:0] od_port_out,
    input wire logic [OD_W-1:0] od_port_oe,
    input wire logic [OD_W-1:0] od_pad_oe,
    input wire logic port9_bit0_in,
    input wire logic port9_bit3_in,
    input wire logic port4_bit1_in,
    input wire logic [2:0] serial_rx
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Write answers two edges after both items, read one edge after
    wr_answer_a: assert property ((s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    // Answers drop once taken
    b_release_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write answer stuck");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read answer stuck");
    aw_refuse_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    reset_value_a: assert property ($rose(aresetn) |->
        port_b_oe == PORTB_DIR_RST && port_b_out == PORTB_LATCH_RST)
        else $error("port reset value wrong");
    od_drive_a: assert property ((od_pad_oe & ~od_port_oe) == 5'h00 &&
        (od_port_oe[1:0] & ~od_port_out[1:0] & ~od_pad_oe[1:0]) == 2'h0)
        else $error("open drain pad drive wrong");
    rx_feed_a: assert property (serial_rx ==
        {port4_bit1_in, port9_bit3_in, port9_bit0_in})
        else $error("receive level lost");
endmodule // pbodsw_props
bind pbodsw_top pbodsw_props u_props (.*);

// >>> verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top
    import pbodsw_pkg::*;
;
    logic aclk = 0;
    logic aresetn = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] port_b_in, port_b_out, port_b_oe, portb_ext = 3'h5;
    logic [4:0] od_port_out = 5'h1f, od_port_oe = 5'h1f, od_pad_out;
    logic [4:0] od_pad_oe, od_ext = 5'h1f, od_lvl;
    logic port9_bit1_out = 0, port9_bit4_out = 0, port4_bit2_out = 0;
    logic port9_bit1_oe = 1, port9_bit4_oe = 1, port4_bit2_oe = 1;
    logic port9_bit1_pad_out, port9_bit4_pad_out, port4_bit2_pad_out;
    logic port9_bit1_pad_oe, port9_bit4_pad_oe, port4_bit2_pad_oe;
    logic port9_bit0_in, port9_bit3_in, port4_bit1_in;
    logic [2:0] serial_tx = 3'h5, serial_rx, serial_rx_relocated, tx_lvl;
    logic [2:0] mv [3] = '{3'h0, 3'h3, 3'h7};
    int n_mismatch = 0, tests_run = 0;
    // Clock and receive pads from the far side
    always #12.5 aclk = ~aclk;
    assign port9_bit0_in = od_lvl[OD_PORT9_BIT0];
    assign port9_bit3_in = od_lvl[OD_PORT9_BIT3];
    assign port4_bit1_in = od_lvl[OD_PORT4_BIT1];
    pbodsw_top u_dut (.*);
    pbodsw_pins u_pins (.portb_out(port_b_out), .portb_oe(port_b_oe),
        .portb_ext(portb_ext), .od_out(od_pad_out), .od_oe(od_pad_oe),
        .od_ext(od_ext), .portb_lvl(port_b_in), .od_lvl(od_lvl),
        .tx_out({port4_bit2_pad_out, port9_bit4_pad_out, port9_bit1_pad_out}),
        .tx_oe({port4_bit2_pad_oe, port9_bit4_pad_oe, port9_bit1_pad_oe}),
        .tx_lvl(tx_lvl));
    // Write with the given byte strobes, ready sampled before each edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        b = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!b) begin
            @(negedge aclk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end
        `CHK({b, r}, {1'b1, er})
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] er,
        output logic [31:0] d);
        logic ar, v;
        logic [1:0] r;
        v = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!v) begin
            @(negedge aclk);
            ar = s_axi_arready;
            v = s_axi_rvalid;
            r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 0;
        end
        `CHK({v, r}, {1'b1, er})
    endtask
    task automatic t_rst();
        logic [31:0] d;
        @(negedge aclk);
        `CHK(port_b_oe, PORTB_DIR_RST)
        `CHK(port_b_out, PORTB_LATCH_RST)
        `CHK(od_pad_oe, od_port_oe)
        `CHK(tx_lvl, 3'h0)
        @(posedge aclk);
        rd(PORTB_DATA_ADDR, RESP_OKAY, d);
        `CHK(d, 32'(portb_ext))
        rd(SWAP0_ADDR, RESP_OKAY, d);
        `CHK(d, 32'h0000_0000)
        rd(OD_SEL_ADDR, RESP_OKAY, d);
        `CHK(d, 32'h0000_0000)
        $display("test reset done");
    endtask
    task automatic t_port();
        logic [31:0] d;
        portb_ext <= 3'h0;
        wr(PORTB_DIR_ADDR, 32'hffff_fff5, 4'h1, RESP_OKAY);
        wr(PORTB_DATA_ADDR, 32'hffff_fffb, 4'h1, RESP_OKAY);
        wr(PORTB_DIR_ADDR, 32'h0000_0007, 4'h0, RESP_OKAY);
        wr(10'h3fc, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        rd(10'h3fc, RESP_SLVERR, d);
        `CHK(port_b_oe, 3'h5)
        `CHK(port_b_out, 3'h3)
        rd(PORTB_DATA_ADDR, RESP_OKAY, d);
        `CHK(d, 32'h0000_0001)
        $display("test port done");
    endtask
    task automatic t_od();
        logic [31:0] d;
        for (int i = 0; i < OD_W; i++) begin
            wr(OD_SEL_ADDR, 32'hffff_ffe0 | (1 << i), 4'h1, RESP_OKAY);
            rd(OD_SEL_ADDR, RESP_OKAY, d);
            `CHK(d, 32'(1 << i))
            `CHK(od_pad_oe, 5'h1f ^ 5'(1 << i))
            `CHK(od_pad_out, od_port_out)
        end
        wr(OD_SEL_ADDR, 32'h0000_0000, 4'h1, RESP_OKAY);
        $display("test open drain done");
    endtask
    task automatic t_swap();
        logic [31:0] d;
        od_port_oe <= 5'h00;
        od_ext <= 5'h14;
        for (int k = 0; k < 3; k++) begin
            wr(SWAP0_ADDR, 32'({mv[k], mv[k]}), 4'h1, RESP_OKAY);
            wr(SWAP1_ADDR, 32'({mv[k][2], 1'b0, mv[k][1:0], 1'b0}), 4'h1,
                RESP_OKAY);
            rd(SWAP0_ADDR, RESP_OKAY, d);
            `CHK(d, 32'h0000_0000)
            `CHK(tx_lvl, (mv[k][1] ? serial_tx : 3'h0))
            `CHK({port4_bit2_pad_oe, port9_bit4_pad_oe, port9_bit1_pad_oe},
                (mv[k][2] ? ~serial_tx : 3'h7))
            `CHK(serial_rx_relocated, {3{mv[k][0]}})
            `CHK(serial_rx, 3'h6)
        end
        $display("test swap done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence, with a mid-run reset
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_rst();
        t_port();
        t_od();
        t_swap();
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        t_rst();
        complete_run();
    end
    // Watchdog against a hung handshake
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule // tb_top

// >>> verilog/pbodsw_pin.sv
`timescale 1ns/100ps
// One pad: port function or relocated serial transmit, push-pull or open-drain
module pbodsw_pin
    import pbodsw_pkg::*;
(
    input wire logic port_out,
    input wire logic port_oe,
    input wire logic port_od,
    input wire logic tx_sel,
    input wire logic tx_data,
    input wire logic tx_od,
    output pbodsw_drive_type drive
);
    logic val;
    logic en;
    logic od;

    // Serial transmit takes the pad from the port when relocated
    always_comb begin
        val = tx_sel ? tx_data : port_out;
        en = tx_sel ? 1'b1 : port_oe;
        od = tx_sel ? tx_od : port_od;
        drive.out = val;
        drive.oe = en & ~(od & val); // Open drain releases a high
    end
endmodule // pbodsw_pin

// >>> verilog/pbodsw_pkg.sv
package pbodsw_pkg;
    // Register indices (printed offsets are not all multiples of four)
    localparam logic [7:0] SWAP1_IDX = 8'h15;
    localparam logic [7:0] SWAP0_IDX = 8'h25;
    localparam logic [7:0] PORTB_DATA_IDX = 8'h2c;
    localparam logic [7:0] PORTB_DIR_IDX = 8'h2e;
    localparam logic [7:0] OD_SEL_IDX = 8'h3f;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] SWAP1_ADDR = {SWAP1_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] SWAP0_ADDR = {SWAP0_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] PORTB_DATA_ADDR = {PORTB_DATA_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] PORTB_DIR_ADDR = {PORTB_DIR_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] OD_SEL_ADDR = {OD_SEL_IDX, 2'h0};
    // Widths and reset values
    localparam int PORTB_W = 3;
    localparam int OD_W = 5;
    localparam logic [PORTB_W-1:0] PORTB_LATCH_RST = 3'h7;
    localparam logic [PORTB_W-1:0] PORTB_DIR_RST = 3'h0;
    localparam logic [OD_W-1:0] OD_SEL_RST = 5'h00;
    localparam logic [5:0] SWAP0_RST = 6'h00;
    localparam logic [2:0] SWAP1_RST = 3'h0;
    // Open-drain select bit positions
    localparam int OD_PORT3_BIT0 = 0;
    localparam int OD_PORT3_BIT1 = 1;
    localparam int OD_PORT4_BIT1 = 2;
    localparam int OD_PORT9_BIT0 = 3;
    localparam int OD_PORT9_BIT3 = 4;
    // Swap register 0 fields
    localparam int CH0_RX = 0;
    localparam int CH0_TX = 1;
    localparam int CH0_OD = 2;
    localparam int CH1_RX = 3;
    localparam int CH1_TX = 4;
    localparam int CH1_OD = 5;
    // Swap register 1 fields
    localparam int CH2_RX = 1;
    localparam int CH2_TX = 2;
    localparam int CH2_OD = 4;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // One pad drive as level and enable
    typedef struct packed {
        logic out;
        logic oe;
    } pbodsw_drive_type;

    // Relocation of one serial channel
    typedef struct packed {
        logic rx_reloc;
        logic tx_reloc;
        logic tx_od;
    } pbodsw_swap_type;
endpackage

// >>> verilog/pbodsw_top.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
module pbodsw_top
    import pbodsw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port B pads
    input wire logic [PORTB_W-1:0] port_b_in,
    output logic [PORTB_W-1:0] port_b_out,
    output logic [PORTB_W-1:0] port_b_oe,
    // Open-drain capable pads, in select-bit order
    input wire logic [OD_W-1:0] od_port_out,
    input wire logic [OD_W-1:0] od_port_oe,
    output logic [OD_W-1:0] od_pad_out,
    output logic [OD_W-1:0] od_pad_oe,
    // Transmit-capable pads, drive from their own ports
    input wire logic port9_bit1_out,
    input wire logic port9_bit1_oe,
    input wire logic port9_bit4_out,
    input wire logic port9_bit4_oe,
    input wire logic port4_bit2_out,
    input wire logic port4_bit2_oe,
    output logic port9_bit1_pad_out,
    output logic port9_bit1_pad_oe,
    output logic port9_bit4_pad_out,
    output logic port9_bit4_pad_oe,
    output logic port4_bit2_pad_out,
    output logic port4_bit2_pad_oe,
    // Receive-side pad levels, one per channel
    input wire logic port9_bit0_in,
    input wire logic port9_bit3_in,
    input wire logic port4_bit1_in,
    // Serial channels
    input wire logic [2:0] serial_tx,
    output logic [2:0] serial_rx,
    output logic [2:0] serial_rx_relocated
);
    // Software-visible state
    logic [PORTB_W-1:0] portb_latch_q;
    logic [PORTB_W-1:0] portb_dir_q;
    logic [OD_W-1:0] od_sel_q;
    logic [5:0] swap0_q;
    logic [2:0] swap1_q;

    // Bus-side holding registers
    logic aw_q;
    logic w_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Decoded write strobes
    logic do_write;
    logic wr_hit;
    logic wr_latch;
    logic wr_dir;
    logic wr_od_sel;
    logic wr_swap0;
    logic wr_swap1;

    // Read decode
    logic [31:0] rd_val;
    logic rd_hit;

    // Pad routing
    pbodsw_swap_type sw [3];
    pbodsw_drive_type tx_drv [3];
    pbodsw_drive_type od_drv [OD_W];
    logic [2:0] tx_port_out;
    logic [2:0] tx_port_oe;
    logic [OD_W-1:0] od_tx_sel;

    // Write channel handshake: address and data in either order
    assign s_axi_awready = ~aw_q & ~bvalid_q;
    assign s_axi_wready = ~w_q & ~bvalid_q;
    assign do_write = aw_q & w_q & ~bvalid_q;

    // Write response outputs
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_q <= 1'b0;
        end
    end

    // Address decode for writes
    always_comb begin
        case (awaddr_q)
            SWAP1_ADDR, SWAP0_ADDR, PORTB_DATA_ADDR,
            PORTB_DIR_ADDR, OD_SEL_ADDR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // One strobe per register, byte lane 0 only
    always_comb begin
        wr_latch = 1'b0;
        wr_dir = 1'b0;
        wr_od_sel = 1'b0;
        wr_swap0 = 1'b0;
        wr_swap1 = 1'b0;
        if (do_write && wstrb_q[0]) begin
            case (awaddr_q)
                PORTB_DATA_ADDR: wr_latch = 1'b1;
                PORTB_DIR_ADDR: wr_dir = 1'b1;
                OD_SEL_ADDR: wr_od_sel = 1'b1;
                SWAP0_ADDR: wr_swap0 = 1'b1;
                SWAP1_ADDR: wr_swap1 = 1'b1;
                default: wr_latch = 1'b0; // Unmapped, nothing written
            endcase
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Port B output latch, preset to ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            portb_latch_q <= PORTB_LATCH_RST;
        end else if (wr_latch) begin
            portb_latch_q <= wdata_q[PORTB_W-1:0];
        end
    end

    // Port B direction, write-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            portb_dir_q <= PORTB_DIR_RST;
        end else if (wr_dir) begin
            portb_dir_q <= wdata_q[PORTB_W-1:0];
        end
    end

    // Open-drain selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            od_sel_q <= OD_SEL_RST;
        end else if (wr_od_sel) begin
            od_sel_q <= wdata_q[OD_W-1:0];
        end
    end

    // Swap register 0, write-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap0_q <= SWAP0_RST;
        end else if (wr_swap0) begin
            swap0_q <= wdata_q[5:0];
        end
    end

    // Swap register 1, only bits 4, 2, 1 exist
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap1_q <= SWAP1_RST;
        end else if (wr_swap1) begin
            swap1_q <= {wdata_q[CH2_OD], wdata_q[CH2_TX],
                        wdata_q[CH2_RX]};
        end
    end

    // Read path: write-only registers read as zero
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            PORTB_DATA_ADDR: rd_val[PORTB_W-1:0] = port_b_in;
            OD_SEL_ADDR: rd_val[OD_W-1:0] = od_sel_q;
            SWAP1_ADDR, SWAP0_ADDR, PORTB_DIR_ADDR: rd_val = '0;
            default: rd_hit = 1'b0;
        endcase
    end

    // Read response, data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Port B pads
    assign port_b_out = portb_latch_q;
    assign port_b_oe = portb_dir_q;

    // Per-channel swap fields
    always_comb begin
        // Channel 0 in swap register 0
        sw[0].rx_reloc = swap0_q[CH0_RX];
        sw[0].tx_reloc = swap0_q[CH0_TX];
        sw[0].tx_od = swap0_q[CH0_OD];
        // Channel 1 in swap register 0
        sw[1].rx_reloc = swap0_q[CH1_RX];
        sw[1].tx_reloc = swap0_q[CH1_TX];
        sw[1].tx_od = swap0_q[CH1_OD];
        // Channel 2, kept compact as od, tx, rx
        sw[2].rx_reloc = swap1_q[0];
        sw[2].tx_reloc = swap1_q[1];
        sw[2].tx_od = swap1_q[2];
    end

    // Port drive of the three transmit-capable pads
    always_comb begin
        tx_port_out[0] = port9_bit1_out;
        tx_port_out[1] = port9_bit4_out;
        tx_port_out[2] = port4_bit2_out;
        tx_port_oe[0] = port9_bit1_oe;
        tx_port_oe[1] = port9_bit4_oe;
        tx_port_oe[2] = port4_bit2_oe;
    end

    // Transmit-capable pads, one per channel
    for (genvar i = 0; i < 3; i++) begin : g_tx
        pbodsw_pin u_pin (
            .port_out(tx_port_out[i]),
            .port_oe(tx_port_oe[i]),
            .port_od(1'b0),
            .tx_sel(sw[i].tx_reloc),
            .tx_data(serial_tx[i]),
            .tx_od(sw[i].tx_od),
            .drive(tx_drv[i])
        );
    end

    // Pad drive back out, channel order
    always_comb begin
        port9_bit1_pad_out = tx_drv[0].out;
        port9_bit1_pad_oe = tx_drv[0].oe;
        port9_bit4_pad_out = tx_drv[1].out;
        port9_bit4_pad_oe = tx_drv[1].oe;
        port4_bit2_pad_out = tx_drv[2].out;
        port4_bit2_pad_oe = tx_drv[2].oe;
    end

    // Port-only pads never carry a transmitter
    assign od_tx_sel = '0;

    // Open-drain capable port pads, each its own select bit
    for (genvar j = 0; j < OD_W; j++) begin : g_od
        pbodsw_pin u_pin (
            .port_out(od_port_out[j]),
            .port_oe(od_port_oe[j]),
            .port_od(od_sel_q[j]),
            .tx_sel(od_tx_sel[j]),
            .tx_data(1'b0),
            .tx_od(1'b0),
            .drive(od_drv[j])
        );
        assign od_pad_out[j] = od_drv[j].out;
        assign od_pad_oe[j] = od_drv[j].oe;
    end

    // Receive levels reach the channels whatever the port setting
    always_comb begin
        serial_rx[0] = port9_bit0_in;
        serial_rx[1] = port9_bit3_in;
        serial_rx[2] = port4_bit1_in;
        // Relocation flags tell each channel its pin source
        serial_rx_relocated[0] = sw[0].rx_reloc;
        serial_rx_relocated[1] = sw[1].rx_reloc;
        serial_rx_relocated[2] = sw[2].rx_reloc;
    end
endmodule // pbodsw_top
